// ---- pps_params.svh ----
/*
 Constants for the peripheral input pin select block: register indices,
 field positions, widths and reset values.
 Assumes inclusion by bare name from the package and design modules.
*/
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH

`define PPS_ADDR_W 4
`define PPS_DATA_W 16
`define PPS_FIELD_W 8
`define PPS_NUM_REGS 9
`define PPS_NUM_SINKS 18
`define PPS_NUM_PINS 64

// Register offsets (word index on the register port)
`define PPS_OFF_PWM_10_11 4'h0
`define PPS_OFF_ENC1_PHASE 4'h1
`define PPS_OFF_ENC1_HOME_IDX 4'h2
`define PPS_OFF_ENC2_PHASE 4'h3
`define PPS_OFF_ENC2_HOME_IDX 4'h4
`define PPS_OFF_SER1 4'h5
`define PPS_OFF_SER2 4'h6
`define PPS_OFF_SPI1_CLK_DATA 4'h7
`define PPS_OFF_REFCLK_SPI1_CSEL 4'h8

// Field positions inside each 16-bit selector register
`define PPS_HI_MSB 15
`define PPS_HI_LSB 8
`define PPS_LO_MSB 7
`define PPS_LO_LSB 0

`define PPS_REG_RESET 16'h0000
`define PPS_RDATA_IDLE 16'h0000
`define PPS_SEL_NONE 8'h00

`endif

// ---- pps_pkg.sv ----
/*
 Types shared by the peripheral input pin select block.
 Assumes pps_params.svh is on the include path.
*/
`include "pps_params.svh"

package pps_pkg;
  typedef logic [`PPS_ADDR_W-1:0] pps_addr_t;
  typedef logic [`PPS_DATA_W-1:0] pps_data_t;
  typedef logic [`PPS_FIELD_W-1:0] pps_sel_t;
endpackage : pps_pkg

// ---- pps_sync.sv ----
/*
 Two-flop synchroniser bank for the remappable pin levels.
 Assumes asynchronous pin inputs and a single system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pps_params.svh"

module pps_sync #(
  parameter int WIDTH = `PPS_NUM_PINS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Pins
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : pps_sync

`default_nettype wire

// ---- pps_route.sv ----
/*
 One routing lane: decodes an 8-bit selector into a pin number and
 forwards that pin's synchronised level as a registered output.
 Assumes pins already synchronised to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pps_params.svh"

module pps_route
  import pps_pkg::*;
#(
  parameter int NUM_PINS = `PPS_NUM_PINS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Selector and pins
  input wire pps_pkg::pps_sel_t sel_i,
  input wire logic [NUM_PINS-1:0] pins_i,
  // Peripheral input
  output logic periph_o
);
  localparam int IDX_W = $clog2(NUM_PINS);

  logic sel_valid;
  logic [IDX_W-1:0] pin_idx;
  logic next_periph;

  // Value zero parks the input low; values beyond the pin count do the same
  assign sel_valid = (sel_i != `PPS_SEL_NONE) && (int'(sel_i) <= NUM_PINS);
  assign pin_idx = sel_valid ? IDX_W'(sel_i - 8'h01) : '0;
  assign next_periph = sel_valid & pins_i[pin_idx];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      periph_o <= 1'b0;
    end else begin
      periph_o <= next_periph;
    end
  end
endmodule : pps_route

`default_nettype wire

// ---- pps_input_select.sv ----
/*
 Peripheral input pin select: nine selector registers, each with two
 8-bit fields, route remappable pins to eighteen peripheral inputs.
 Assumes a plain register port on clk_i and asynchronous pin inputs.
*/
// Added by the designer: the register addresses and the strobed register port.
// Behaviour
// [R1] The upper byte of the first register picks the pin for PWM input eleven.
// [R2] The lower byte of the first register picks the pin for PWM input ten.
// [R3] Encoder one phase register routes phase B from its upper byte and phase A from its lower byte.
// [R4] Encoder one home/index register routes home from its upper byte and index from its lower byte.
// [R5] Encoder two phase register routes phase B from its upper byte and phase A from its lower byte.
// [R6] Encoder two home/index register routes home from its upper byte and index from its lower byte.
// [R7] Serial port one register routes data-set-ready from the upper byte and receive from the lower.
// [R8] Serial port two register routes data-set-ready from the upper byte and receive from the lower.
// [R9] SPI one register routes serial clock from the upper byte and data input from the lower.
// [R10] The upper byte of the last register picks the pin for the reference clock input.
// [R11] The lower byte of the last register picks the pin for SPI one client select.
// [R12] Every selector field is read/write and clears to zero on reset.
// [R13] Each selector decodes to one pin whose synchronised level drives the peripheral input; zero and values above 64 pick no pin and hold the input low.
`timescale 1ns/1ps
`default_nettype none
`include "pps_params.svh"

module pps_input_select
  import pps_pkg::*;
#(
  parameter int NUM_PINS = `PPS_NUM_PINS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire pps_pkg::pps_addr_t addr_i,
  input wire pps_pkg::pps_data_t wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output pps_pkg::pps_data_t rdata_o,
  // Remappable pins
  input wire logic [NUM_PINS-1:0] remappable_pin_i,
  // PWM inputs
  output logic pwm_in10_o,
  output logic pwm_in11_o,
  // Quadrature encoder one
  output logic enc1_phase_a_o,
  output logic enc1_phase_b_o,
  output logic enc1_index_o,
  output logic enc1_home_o,
  // Quadrature encoder two
  output logic enc2_phase_a_o,
  output logic enc2_phase_b_o,
  output logic enc2_index_o,
  output logic enc2_home_o,
  // Serial ports
  output logic ser1_rx_o,
  output logic ser1_dsr_o,
  output logic ser2_rx_o,
  output logic ser2_dsr_o,
  // SPI one and reference clock
  output logic spi1_din_o,
  output logic spi1_clk_o,
  output logic spi1_csel_o,
  output logic refclk_in_o
);
  import pps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  pps_data_t sel_reg [`PPS_NUM_REGS];
  pps_data_t next_rdata;
  logic addr_hit;
  logic [`PPS_NUM_REGS-1:0] wr_hit;

  function automatic logic reg_match(input pps_addr_t a, input int idx);
    reg_match = (a == `PPS_ADDR_W'(idx));
  endfunction : reg_match

  // Offsets are 0..8 in order, so index equals offset
  assign addr_hit = (addr_i < `PPS_ADDR_W'(`PPS_NUM_REGS));

  genvar gr;
  generate
    for (gr = 0; gr < `PPS_NUM_REGS; gr++) begin : g_reg
      assign wr_hit[gr] = write_i & reg_match(addr_i, gr);

      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          sel_reg[gr] <= `PPS_REG_RESET; // R12
        end else if (wr_hit[gr]) begin
          sel_reg[gr] <= wdata_i; // R12
        end
      end
    end
  endgenerate

  // Unmapped reads return zero; data stands only the cycle after the strobe
  assign next_rdata = (read_i && addr_hit) ? sel_reg[addr_i] : `PPS_RDATA_IDLE; // R12

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= `PPS_RDATA_IDLE;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selector fields

  pps_sel_t pwm_in11_pin_sel, pwm_in10_pin_sel;
  pps_sel_t enc1_phase_b_pin_sel, enc1_phase_a_pin_sel;
  pps_sel_t enc1_home_pin_sel, enc1_index_pin_sel;
  pps_sel_t enc2_phase_b_pin_sel, enc2_phase_a_pin_sel;
  pps_sel_t enc2_home_pin_sel, enc2_index_pin_sel;
  pps_sel_t ser1_dsr_pin_sel, ser1_rx_pin_sel;
  pps_sel_t ser2_dsr_pin_sel, ser2_rx_pin_sel;
  pps_sel_t spi1_clk_pin_sel, spi1_din_pin_sel;
  pps_sel_t refclk_in_pin_sel, spi1_csel_pin_sel;

  assign pwm_in11_pin_sel = sel_reg[`PPS_OFF_PWM_10_11][`PPS_HI_MSB:`PPS_HI_LSB]; // R1
  assign pwm_in10_pin_sel = sel_reg[`PPS_OFF_PWM_10_11][`PPS_LO_MSB:`PPS_LO_LSB]; // R2
  assign enc1_phase_b_pin_sel = sel_reg[`PPS_OFF_ENC1_PHASE][`PPS_HI_MSB:`PPS_HI_LSB]; // R3
  assign enc1_phase_a_pin_sel = sel_reg[`PPS_OFF_ENC1_PHASE][`PPS_LO_MSB:`PPS_LO_LSB]; // R3
  assign enc1_home_pin_sel = sel_reg[`PPS_OFF_ENC1_HOME_IDX][`PPS_HI_MSB:`PPS_HI_LSB]; // R4
  assign enc1_index_pin_sel = sel_reg[`PPS_OFF_ENC1_HOME_IDX][`PPS_LO_MSB:`PPS_LO_LSB]; // R4
  assign enc2_phase_b_pin_sel = sel_reg[`PPS_OFF_ENC2_PHASE][`PPS_HI_MSB:`PPS_HI_LSB]; // R5
  assign enc2_phase_a_pin_sel = sel_reg[`PPS_OFF_ENC2_PHASE][`PPS_LO_MSB:`PPS_LO_LSB]; // R5
  assign enc2_home_pin_sel = sel_reg[`PPS_OFF_ENC2_HOME_IDX][`PPS_HI_MSB:`PPS_HI_LSB]; // R6
  assign enc2_index_pin_sel = sel_reg[`PPS_OFF_ENC2_HOME_IDX][`PPS_LO_MSB:`PPS_LO_LSB]; // R6
  assign ser1_dsr_pin_sel = sel_reg[`PPS_OFF_SER1][`PPS_HI_MSB:`PPS_HI_LSB]; // R7
  assign ser1_rx_pin_sel = sel_reg[`PPS_OFF_SER1][`PPS_LO_MSB:`PPS_LO_LSB]; // R7
  assign ser2_dsr_pin_sel = sel_reg[`PPS_OFF_SER2][`PPS_HI_MSB:`PPS_HI_LSB]; // R8
  assign ser2_rx_pin_sel = sel_reg[`PPS_OFF_SER2][`PPS_LO_MSB:`PPS_LO_LSB]; // R8
  assign spi1_clk_pin_sel = sel_reg[`PPS_OFF_SPI1_CLK_DATA][`PPS_HI_MSB:`PPS_HI_LSB]; // R9
  assign spi1_din_pin_sel = sel_reg[`PPS_OFF_SPI1_CLK_DATA][`PPS_LO_MSB:`PPS_LO_LSB]; // R9
  assign refclk_in_pin_sel = sel_reg[`PPS_OFF_REFCLK_SPI1_CSEL][`PPS_HI_MSB:`PPS_HI_LSB]; // R10
  assign spi1_csel_pin_sel = sel_reg[`PPS_OFF_REFCLK_SPI1_CSEL][`PPS_LO_MSB:`PPS_LO_LSB]; // R11

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and routing lanes

  logic [NUM_PINS-1:0] pin_sync;
  pps_sel_t lane_sel [`PPS_NUM_SINKS];
  logic [`PPS_NUM_SINKS-1:0] lane_out;

  pps_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(remappable_pin_i),
    .sync_o(pin_sync)
  );

  assign lane_sel[0] = pwm_in10_pin_sel;
  assign lane_sel[1] = pwm_in11_pin_sel;
  assign lane_sel[2] = enc1_phase_a_pin_sel;
  assign lane_sel[3] = enc1_phase_b_pin_sel;
  assign lane_sel[4] = enc1_index_pin_sel;
  assign lane_sel[5] = enc1_home_pin_sel;
  assign lane_sel[6] = enc2_phase_a_pin_sel;
  assign lane_sel[7] = enc2_phase_b_pin_sel;
  assign lane_sel[8] = enc2_index_pin_sel;
  assign lane_sel[9] = enc2_home_pin_sel;
  assign lane_sel[10] = ser1_rx_pin_sel;
  assign lane_sel[11] = ser1_dsr_pin_sel;
  assign lane_sel[12] = ser2_rx_pin_sel;
  assign lane_sel[13] = ser2_dsr_pin_sel;
  assign lane_sel[14] = spi1_din_pin_sel;
  assign lane_sel[15] = spi1_clk_pin_sel;
  assign lane_sel[16] = spi1_csel_pin_sel;
  assign lane_sel[17] = refclk_in_pin_sel;

  // A selector change takes effect on the lane output one clock later
  genvar gl;
  generate
    for (gl = 0; gl < `PPS_NUM_SINKS; gl++) begin : g_lane
      pps_route #(
        .NUM_PINS(NUM_PINS)
      ) u_route (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sel_i(lane_sel[gl]),
        .pins_i(pin_sync),
        .periph_o(lane_out[gl])
      ); // R13
    end
  endgenerate

  assign pwm_in10_o = lane_out[0];
  assign pwm_in11_o = lane_out[1];
  assign enc1_phase_a_o = lane_out[2];
  assign enc1_phase_b_o = lane_out[3];
  assign enc1_index_o = lane_out[4];
  assign enc1_home_o = lane_out[5];
  assign enc2_phase_a_o = lane_out[6];
  assign enc2_phase_b_o = lane_out[7];
  assign enc2_index_o = lane_out[8];
  assign enc2_home_o = lane_out[9];
  assign ser1_rx_o = lane_out[10];
  assign ser1_dsr_o = lane_out[11];
  assign ser2_rx_o = lane_out[12];
  assign ser2_dsr_o = lane_out[13];
  assign spi1_din_o = lane_out[14];
  assign spi1_clk_o = lane_out[15];
  assign spi1_csel_o = lane_out[16];
  assign refclk_in_o = lane_out[17];
endmodule : pps_input_select

`default_nettype wire

// ---- pps_input_select_assertions.sv ----
/*
 Checker for the pin select block: register port and the two lanes of the first register.
 Assumes it is bound to pps_input_select and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module pps_input_select_assertions
  import pps_pkg::*;
#(
  parameter int NUM_PINS = 64
) (
  // Clock, reset and register port
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire pps_pkg::pps_addr_t addr_i,
  input wire pps_pkg::pps_data_t wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire pps_pkg::pps_data_t rdata_o,
  // Pins and watched lanes
  input wire logic [NUM_PINS-1:0] remappable_pin_i,
  input wire logic pwm_in10_o,
  input wire logic pwm_in11_o
);
  pps_data_t shadow;
  pps_sel_t lo_d;
  pps_sel_t hi_d;
  logic [NUM_PINS-1:0] p1;
  logic [NUM_PINS-1:0] p2;
  logic [NUM_PINS-1:0] p3;
  ////////////////////////////////////////////////////////////////////////
  // Delay line mirrors two sync flops plus the lane register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shadow <= '0;
      lo_d <= '0;
      hi_d <= '0;
      p1 <= '0;
      p2 <= '0;
      p3 <= '0;
    end else begin
      if (write_i && addr_i == 4'h0) shadow <= wdata_i;
      lo_d <= shadow[7:0];
      hi_d <= shadow[15:8];
      p1 <= remappable_pin_i;
      p2 <= p1;
      p3 <= p2;
    end
  end
  wire lo_pin = lo_d != 8'h00 && lo_d <= NUM_PINS && p3[lo_d - 8'h01];
  wire hi_pin = hi_d != 8'h00 && hi_d <= NUM_PINS && p3[hi_d - 8'h01];
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  rdata_idle_a: assert property (!$past(read_i) |-> rdata_o == 16'h0000)
    else $error("read data not idle");
  unmapped_read_a: assert property (read_i && addr_i > 4'h8 |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  write_read_a: assert property (write_i && addr_i <= 4'h8 ##1 read_i && addr_i == $past(addr_i)
    |=> rdata_o == $past(wdata_i, 2)) else $error("read after write wrong");
  first_readback_a: assert property (read_i && addr_i == 4'h0 |=> rdata_o == $past(shadow))
    else $error("first register readback wrong");
  lane_lo_a: assert property (pwm_in10_o == lo_pin)
    else $error("lower lane wrong");
  lane_hi_a: assert property (pwm_in11_o == hi_pin)
    else $error("upper lane wrong");
  none_zero_a: assert property (shadow[15:8] == 8'h00 ##1 shadow[15:8] == 8'h00 |-> !pwm_in11_o)
    else $error("unselected lane not zero");
  reset_zero_a: assert property (disable iff (1'b0) !reset_n_i |-> rdata_o == 16'h0000 && !pwm_in10_o)
    else $error("outputs not zero in reset");
endmodule : pps_input_select_assertions

bind pps_input_select pps_input_select_assertions #(.NUM_PINS(NUM_PINS)) chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
  .read_i(read_i), .rdata_o(rdata_o), .remappable_pin_i(remappable_pin_i),
  .pwm_in10_o(pwm_in10_o), .pwm_in11_o(pwm_in11_o));

`default_nettype wire

// ---- pps_pin_model.sv ----
/*
 Model of the remappable pins: levels asked for by the bench appear on the pins.
 Assumes a free-running system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pps_pin_model #(
  parameter int NUM_PINS = 64
) (
  // Clock
  input wire logic clk_i,
  // Requested levels and pins
  input wire logic [NUM_PINS-1:0] level_i,
  output logic [NUM_PINS-1:0] pin_o
);
  initial pin_o = '0;
  // Pins move away from the edge, as asynchronous levels would
  always @(posedge clk_i) begin
    pin_o <= #25 level_i;
  end
endmodule : pps_pin_model

`default_nettype wire

// ---- pps_input_select_tb_top.sv ----
/*
 Bench for the pin select block: a table of selector writes, pin levels and lanes.
 Assumes the checker is bound to the design and pins come from the pin model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end

module pps_input_select_tb_top;
  import pps_pkg::*;
  typedef struct {pps_addr_t a; pps_data_t d; logic [63:0] p; logic [1:0] e;} pps_row_s;
  logic clk_i = 0, reset_n_i = 1, write_i = 0, read_i = 0;
  pps_addr_t addr_i = '0;
  pps_data_t wdata_i = '0, rdata_o, rd;
  logic [63:0] level = '0, pins;
  logic pwm_in10_o, pwm_in11_o, enc1_phase_a_o, enc1_phase_b_o, enc1_index_o, enc1_home_o;
  logic enc2_phase_a_o, enc2_phase_b_o, enc2_index_o, enc2_home_o, ser1_rx_o, ser1_dsr_o;
  logic ser2_rx_o, ser2_dsr_o, spi1_din_o, spi1_clk_o, spi1_csel_o, refclk_in_o;
  int failures = 0, samples_checked = 0, cycles = 0;
  // Selectors hit pin one, pin 64, zero and 65 (both select nothing)
  pps_row_s rows [9] = '{'{4'h0, 16'h0302, 64'h4, 2'b10}, '{4'h1, 16'h0104, 64'h8, 2'b01},
    '{4'h2, 16'h4001, 64'h8000_0000_0000_0001, 2'b11}, '{4'h3, 16'h4100, '1, 2'b00},
    '{4'h4, 16'h0a05, 64'h200, 2'b10}, '{4'h5, 16'h2021, 64'h1_0000_0000, 2'b01},
    '{4'h6, 16'h1010, 64'h8000, 2'b11}, '{4'h7, 16'h0807, 64'h40, 2'b01},
    '{4'h8, 16'h3f02, 64'h4000_0000_0000_0002, 2'b11}};
  always #50 clk_i = ~clk_i;
  pps_pin_model #(.NUM_PINS(64)) pin_m (.clk_i(clk_i), .level_i(level), .pin_o(pins));
  pps_input_select #(.NUM_PINS(64)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .remappable_pin_i(pins),
    .pwm_in10_o(pwm_in10_o), .pwm_in11_o(pwm_in11_o), .enc1_phase_a_o(enc1_phase_a_o),
    .enc1_phase_b_o(enc1_phase_b_o), .enc1_index_o(enc1_index_o), .enc1_home_o(enc1_home_o),
    .enc2_phase_a_o(enc2_phase_a_o), .enc2_phase_b_o(enc2_phase_b_o), .enc2_index_o(enc2_index_o),
    .enc2_home_o(enc2_home_o), .ser1_rx_o(ser1_rx_o), .ser1_dsr_o(ser1_dsr_o), .ser2_rx_o(ser2_rx_o),
    .ser2_dsr_o(ser2_dsr_o), .spi1_din_o(spi1_din_o), .spi1_clk_o(spi1_clk_o),
    .spi1_csel_o(spi1_csel_o), .refclk_in_o(refclk_in_o));
  ////////////////////////////////////////////////////////////////////////
  // Lane pair of a register, upper field first
  function automatic logic [1:0] pair(input pps_addr_t a);
    case (a)
      4'h0: pair = {pwm_in11_o, pwm_in10_o};
      4'h1: pair = {enc1_phase_b_o, enc1_phase_a_o};
      4'h2: pair = {enc1_home_o, enc1_index_o};
      4'h3: pair = {enc2_phase_b_o, enc2_phase_a_o};
      4'h4: pair = {enc2_home_o, enc2_index_o};
      4'h5: pair = {ser1_dsr_o, ser1_rx_o};
      4'h6: pair = {ser2_dsr_o, ser2_rx_o};
      4'h7: pair = {spi1_clk_o, spi1_din_o};
      default: pair = {refclk_in_o, spi1_csel_o};
    endcase
  endfunction : pair
  task automatic wr(input pps_addr_t a, input pps_data_t d);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask : wr
  task automatic rdr(input pps_addr_t a);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    @(negedge clk_i);
    rd = rdata_o;
    @(posedge clk_i);
  endtask : rdr
  task automatic print_verdict;
    $display("checked %0d, failed %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    // A real falling edge at time zero, so every flop is cleared before the first clock edge
    reset_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      rdr(4'(i));
      `CHK(rd, 16'h0000)
    end
    $display("test reset values done");
    foreach (rows[i]) begin
      level <= rows[i].p;
      wr(rows[i].a, rows[i].d);
      rdr(rows[i].a);
      `CHK(rd, rows[i].d)
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      `CHK(pair(rows[i].a), rows[i].e)
      @(posedge clk_i);
    end
    $display("test table done");
    wr(4'h9, 16'hffff);
    rdr(4'h9);
    `CHK(rd, 16'h0000)
    rdr(4'h0);
    `CHK(rd, 16'h0302)
    $display("test unmapped done");
    reset_n_i <= 1'b0;
    @(negedge clk_i);
    `CHK({pair(4'h8), pair(4'h6)}, 4'h0)
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rdr(4'h8);
    `CHK(rd, 16'h0000)
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : pps_input_select_tb_top

`default_nettype wire
